/* hdl/sac_pkg.sv */
// Package: register map, field positions and timing for the converter sequencer
package sac_pkg;
	// Register byte addresses: printed offsets are not multiples of four, so index * 4
	localparam logic [7:0] CTRL_ZERO_IDX = 8'h14;
	localparam logic [7:0] CTRL_ONE_IDX = 8'h15;
	localparam logic [7:0] RESULT_IDX = 8'h16;
	localparam logic [7:0] STATUS_IDX = 8'h17;
	localparam logic [9:0] CTRL_ZERO_ADDR = {CTRL_ZERO_IDX, 2'b00};
	localparam logic [9:0] CTRL_ONE_ADDR = {CTRL_ONE_IDX, 2'b00};
	localparam logic [9:0] RESULT_ADDR = {RESULT_IDX, 2'b00};
	localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
	// Writable masks; unimplemented bits read zero
	localparam logic [7:0] CTRL_ZERO_MASK = 8'hF5;
	localparam logic [7:0] CTRL_ONE_MASK = 8'hEF;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Field positions
	localparam int POWER_BIT = 0;
	localparam int GO_BIT = 2;
	localparam int CHAN_LSB = 4;
	localparam int REF_BIT = 0;
	localparam int PCFG_LSB = 1;
	localparam int JUST_BIT = 5;
	localparam int CLKSEL_LSB = 6;
	localparam int DONE_BIT = 0;
	// Clock selections and divisors
	localparam logic [1:0] CLK_DIV8 = 2'h0;
	localparam logic [1:0] CLK_DIV32 = 2'h1;
	localparam logic [1:0] CLK_DIV64 = 2'h2;
	localparam logic [1:0] CLK_RC = 2'h3;
	localparam logic [6:0] DIV8_HALF = 7'h04;
	localparam logic [6:0] DIV32_HALF = 7'h10;
	localparam logic [6:0] DIV64_HALF = 7'h20;
	// Sequence lengths in bit periods, result width and channel count
	localparam logic [3:0] CONV_PERIODS = 4'hC;
	localparam logic [3:0] RECOVER_PERIODS = 4'h2;
	localparam logic [3:0] FIRST_BIT_PERIOD = 4'h2;
	localparam int RESULT_BITS = 10;
	localparam int CHANNELS = 16;
	// Instruction cycle of the core, in oscillator cycles
	localparam logic [1:0] INSTR_CYCLES = 2'h3;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_ACQ = 3'b001,
		ST_DELAY = 3'b010,
		ST_CONV = 3'b011,
		ST_RECOVER = 3'b100
	} sac_state_t;

	typedef struct packed {
		logic [7:0] ctrl_zero;
		logic [7:0] ctrl_one;
		logic [15:0] result;
		logic done;
		sac_state_t state;
		logic [6:0] div_cnt;
		logic bit_clk;
		logic rc_s1;
		logic rc_s2;
		logic rc_s3;
		logic [3:0] period_cnt;
		logic [1:0] delay_cnt;
		logic [9:0] sar;
		logic [9:0] trial;
		logic tick_seen;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic sample_conn;
		logic powered;
		logic [15:0] analog_map;
	} sac_regs_t;
endpackage

/* hdl/sac_sequencer.sv */
// Converter control sequencer: APB registers, bit clock, acquisition and SAR sequencing
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module sac_sequencer
	import sac_pkg::*;
#(
	parameter int DATA_W = RESULT_BITS
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [31:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic RC_CLK_I,
	input wire logic SLEEP_I,
	input wire logic COMPARATOR_I,
	output logic [DATA_W-1:0] DAC_CODE_O,
	output logic [3:0] CHANNEL_O,
	output logic SAMPLE_CONNECT_O,
	output logic EXT_REF_O,
	output logic POWER_ON_O,
	output logic [CHANNELS-1:0] ANALOG_PIN_O,
	output logic DONE_O
);

	// ==========================================================================
	// State
	// ==========================================================================
	sac_regs_t r_reg;
	sac_regs_t r_next;

	logic [1:0] clk_sel;
	logic rc_mode;
	logic [6:0] half;
	logic bit_tick;
	logic access;
	logic wr_zero;
	logic go_write;
	logic go_clear;
	logic running;
	logic [2:0] pcfg;
	logic [15:0] just_val;
	logic [31:0] rdata;
	logic unmapped;

	always_comb begin
		clk_sel = r_reg.ctrl_one[CLKSEL_LSB +: 2];
		rc_mode = (clk_sel == CLK_RC);
		access = PSEL_I && PENABLE_I;
		wr_zero = access && PWRITE_I && (PADDR_I[9:0] == CTRL_ZERO_ADDR);
		go_write = wr_zero && PWDATA_I[GO_BIT] && r_reg.ctrl_zero[POWER_BIT];
		go_clear = wr_zero && !PWDATA_I[GO_BIT];
		running = r_reg.ctrl_zero[POWER_BIT] && !(SLEEP_I && !rc_mode);
		pcfg = r_reg.ctrl_one[PCFG_LSB +: 3];
		unique case (clk_sel)
			CLK_DIV8: half = DIV8_HALF;
			CLK_DIV32: half = DIV32_HALF;
			CLK_DIV64: half = DIV64_HALF;
			CLK_RC: half = DIV64_HALF;
		endcase
		// Bit-clock rising edge, from divider or synchronised RC
		if (rc_mode) begin
			bit_tick = r_reg.rc_s2 && !r_reg.rc_s3;
		end else begin
			bit_tick = !r_reg.bit_clk && (r_reg.div_cnt == half - 7'h01);
		end
	end

	// ==========================================================================
	// Next state
	// ==========================================================================
	always_comb begin
		r_next = r_reg;
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;
		// RC clock crosses into this domain via two flops
		r_next.rc_s1 = RC_CLK_I;
		r_next.rc_s2 = r_reg.rc_s1;
		r_next.rc_s3 = r_reg.rc_s2;
		if (r_reg.div_cnt == half - 7'h01) begin
			r_next.div_cnt = 7'h00;
			r_next.bit_clk = !r_reg.bit_clk;
		end else begin
			r_next.div_cnt = r_reg.div_cnt + 7'h01;
		end

		// Register writes take effect at the APB completion edge
		if (access && PWRITE_I) begin
			unique case (PADDR_I[9:0])
				CTRL_ZERO_ADDR: begin
					// Go bit only starts when already powered; power and go together do not start
					r_next.ctrl_zero = PWDATA_I[7:0] & CTRL_ZERO_MASK & ~(8'h01 << GO_BIT);
					r_next.ctrl_zero[GO_BIT] = go_write || (r_reg.ctrl_zero[GO_BIT] &&
						!go_clear && PWDATA_I[POWER_BIT]);
				end
				CTRL_ONE_ADDR: r_next.ctrl_one = PWDATA_I[7:0] & CTRL_ONE_MASK;
				RESULT_ADDR: r_next.result = PWDATA_I[15:0];
				STATUS_ADDR: begin
					if (!PWDATA_I[DONE_BIT]) begin
						r_next.done = 1'b0;
					end
				end
				default: r_next.pslverr = 1'b0;
			endcase
		end

		r_next.powered = running;
		r_next.sample_conn = 1'b0;
		unique case (r_reg.state)
			ST_OFF: begin
				if (running) begin
					r_next.state = ST_ACQ;
				end
			end
			ST_ACQ: begin
				r_next.sample_conn = 1'b1;
				if (go_write) begin
					r_next.delay_cnt = 2'h0;
					r_next.period_cnt = 4'h0;
					r_next.tick_seen = 1'b0;
					r_next.sar = '0;
					r_next.trial = 10'h200;
					r_next.state = rc_mode ? ST_DELAY : ST_CONV;
				end
			end
			ST_DELAY: begin
				r_next.delay_cnt = r_reg.delay_cnt + 2'h1;
				if (r_reg.delay_cnt == INSTR_CYCLES - 2'h1) begin
					r_next.state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (bit_tick) begin
					r_next.period_cnt = r_reg.period_cnt + 4'h1;
					// Periods 2..11 each resolve one bit, MSB first
					if (r_reg.period_cnt >= FIRST_BIT_PERIOD - 4'h1 &&
						r_reg.period_cnt < CONV_PERIODS - 4'h1) begin
						if (COMPARATOR_I) begin
							r_next.sar = r_reg.sar | r_reg.trial;
						end
						r_next.trial = r_reg.trial >> 1;
					end
					if (r_reg.period_cnt == CONV_PERIODS - 4'h1) begin
						// Result, go clear and done all together
						if (r_reg.ctrl_one[JUST_BIT]) begin
							r_next.result = {6'h00, r_reg.sar};
						end else begin
							r_next.result = {r_reg.sar, 6'h00};
						end
						r_next.ctrl_zero[GO_BIT] = 1'b0;
						r_next.done = 1'b1;
						r_next.period_cnt = 4'h0;
						r_next.state = ST_RECOVER;
					end
				end
				if (go_clear) begin
					r_next.period_cnt = 4'h0;
					r_next.state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (bit_tick) begin
					r_next.period_cnt = r_reg.period_cnt + 4'h1;
					if (r_reg.period_cnt == RECOVER_PERIODS - 4'h1) begin
						r_next.state = ST_ACQ;
					end
				end
			end
			default: r_next.state = ST_OFF;
		endcase
		if (!running) begin
			// Shut down or sleep without RC: abort, go cleared
			r_next.state = ST_OFF;
			r_next.sample_conn = 1'b0;
			if (r_reg.state != ST_OFF) begin
				r_next.ctrl_zero[GO_BIT] = 1'b0;
			end
		end

		// Pin map: n highest pins of each octet go digital
		for (int i = 0; i < 8; i++) begin
			// Top code turns the whole octet digital, not just seven pins
			r_next.analog_map[i] = (pcfg != 3'h7) && (i < 8 - int'(pcfg));
			r_next.analog_map[i + 8] = r_next.analog_map[i];
		end

		// Read data
		unmapped = 1'b0;
		just_val = r_reg.result;
		unique case (PADDR_I[9:0])
			CTRL_ZERO_ADDR: rdata = {24'h000000, r_reg.ctrl_zero & CTRL_ZERO_MASK};
			CTRL_ONE_ADDR: rdata = {24'h000000, r_reg.ctrl_one & CTRL_ONE_MASK};
			RESULT_ADDR: rdata = {16'h0000, just_val};
			STATUS_ADDR: rdata = {29'h00000000, r_reg.state};
			default: begin
				rdata = 32'h00000000;
				unmapped = 1'b1;
			end
		endcase
		if (PADDR_I[9:0] == STATUS_ADDR) begin
			rdata[DONE_BIT] = r_reg.done;
			rdata[3:1] = r_reg.state;
		end
		if (PSEL_I && !PENABLE_I) begin
			r_next.prdata = rdata;
			r_next.pready = 1'b1;
			r_next.pslverr = unmapped;
		end
		if (access) begin
			r_next.pready = 1'b0;
		end
		// Done: a completion in the same cycle as a clear wins
		if (r_reg.state == ST_CONV && bit_tick && r_reg.period_cnt == CONV_PERIODS - 4'h1
			&& !go_clear) begin
			r_next.done = 1'b1;
		end
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			r_reg <= '0;
			r_reg.ctrl_zero <= CTRL_RESET;
			r_reg.ctrl_one <= CTRL_RESET;
			r_reg.analog_map <= 16'hFFFF;
		end else begin
			r_reg <= r_next;
		end
	end

	always_comb begin
		PRDATA_O = r_reg.prdata;
		PREADY_O = r_reg.pready;
		PSLVERR_O = r_reg.pslverr;
		DAC_CODE_O = r_reg.sar | r_reg.trial;
		CHANNEL_O = r_reg.ctrl_zero[CHAN_LSB +: 4];
		SAMPLE_CONNECT_O = r_reg.sample_conn;
		EXT_REF_O = r_reg.ctrl_one[REF_BIT];
		POWER_ON_O = r_reg.powered;
		ANALOG_PIN_O = r_reg.analog_map;
		DONE_O = r_reg.done;
	end

endmodule // sac_sequencer

/* tb/sac_sequencer_properties.sv */
// Checker: port-level timing properties of the converter sequencer
`timescale 1ns/1ps
module sac_sequencer_properties
	import sac_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [31:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic [3:0] CHANNEL_O,
	input wire logic SAMPLE_CONNECT_O,
	input wire logic POWER_ON_O,
	input wire logic [CHANNELS-1:0] ANALOG_PIN_O,
	input wire logic DONE_O
);
	// ==========
	// Properties
	logic wr0;
	assign wr0 = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && PADDR_I[9:0] == CTRL_ZERO_ADDR;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	property p_ready; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
	a_ready: assert property (p_ready) else $error("ready late");
	property p_once; PREADY_O |=> !PREADY_O; endproperty
	a_once: assert property (p_once) else $error("ready too long");
	property p_err; PSLVERR_O |-> PREADY_O; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_chan; wr0 |=> CHANNEL_O == $past(PWDATA_I[7:4]); endproperty
	a_chan: assert property (p_chan) else $error("channel not routed");
	property p_map; ANALOG_PIN_O[15:8] == ANALOG_PIN_O[7:0]; endproperty
	a_map: assert property (p_map) else $error("octets differ");
	// Even the fastest bit clock needs several cycles per period
	property p_rec; $rose(DONE_O) |-> !SAMPLE_CONNECT_O [*4]; endproperty
	a_rec: assert property (p_rec) else $error("sampling too soon");
	property p_conv; $rose(DONE_O) |-> !$past(SAMPLE_CONNECT_O, 8); endproperty
	a_conv: assert property (p_conv) else $error("conversion too short");
	property p_off; wr0 && !PWDATA_I[0] |=> ##1 !POWER_ON_O && !SAMPLE_CONNECT_O; endproperty
	a_off: assert property (p_off) else $error("still powered");
endmodule // sac_sequencer_properties

bind sac_sequencer sac_sequencer_properties u_props (
	.CLK_I(CLK_I),
	.RST_N_I(RST_N_I),
	.PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I),
	.PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O),
	.CHANNEL_O(CHANNEL_O),
	.SAMPLE_CONNECT_O(SAMPLE_CONNECT_O),
	.POWER_ON_O(POWER_ON_O),
	.ANALOG_PIN_O(ANALOG_PIN_O),
	.DONE_O(DONE_O)
);

/* tb/tb_sac_sequencer.sv */
// Testbench: self-checking register and conversion tests for the sequencer
`timescale 1ns/1ps
module tb_sac_sequencer;
	import sac_pkg::*;
	logic CLK_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic PSEL_I = 1'b0;
	logic PENABLE_I = 1'b0;
	logic PWRITE_I = 1'b0;
	logic [31:0] PADDR_I = 32'h0;
	logic [31:0] PWDATA_I = 32'h0;
	logic RC_CLK_I = 1'b0;
	logic SLEEP_I = 1'b0;
	logic COMPARATOR_I = 1'b0;
	logic [31:0] PRDATA_O;
	logic PREADY_O;
	logic PSLVERR_O;
	logic [RESULT_BITS-1:0] DAC_CODE_O;
	logic [3:0] CHANNEL_O;
	logic SAMPLE_CONNECT_O;
	logic EXT_REF_O;
	logic POWER_ON_O;
	logic [CHANNELS-1:0] ANALOG_PIN_O;
	logic DONE_O;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h268C;
	logic [9:0] vin = 10'h0;
	logic [2:0] rc_cnt = 3'h0;

	sac_sequencer u_dut (
		.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
		.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
		.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RC_CLK_I(RC_CLK_I), .SLEEP_I(SLEEP_I),
		.COMPARATOR_I(COMPARATOR_I), .DAC_CODE_O(DAC_CODE_O), .CHANNEL_O(CHANNEL_O),
		.SAMPLE_CONNECT_O(SAMPLE_CONNECT_O), .EXT_REF_O(EXT_REF_O), .POWER_ON_O(POWER_ON_O),
		.ANALOG_PIN_O(ANALOG_PIN_O), .DONE_O(DONE_O)
	);

	always #20 CLK_I = ~CLK_I;

	// ==========
	// Analog side: comparator lags one cycle, RC clock period is 10 cycles
	always @(posedge CLK_I) begin
		cyc <= cyc + 1;
		COMPARATOR_I <= vin >= DAC_CODE_O;
		rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
		if (rc_cnt == 3'h4) begin
			RC_CLK_I <= ~RC_CLK_I;
		end
		if (cyc == 30000) begin
			n_errors++;
			$display("unexpected at %0t: timeout", $time);
			end_sim;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] res(input logic [9:0] v, input logic j);
		return j ? {22'h0, v} : {16'h0, v, 6'h00};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			n_errors++;
			$display("unexpected at %0t: got %0h, want %0h", $time, g, x);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge CLK_I);
		PSEL_I <= 1'b1;
		PWRITE_I <= w;
		PADDR_I <= {22'h0, a};
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		@(posedge CLK_I);
		while (PREADY_O !== 1'b1) @(posedge CLK_I);
		// Answer taken at the edge where ready is sampled high
		r = PRDATA_O;
		e = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
		#1;
	endtask
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		logic [31:0] r;
		logic e;
		logic [3:0] ch;
		logic j;
		int t0;
		int p;
		wt(3);
		RST_N_I <= 1'b1;
		apb(0, CTRL_ZERO_ADDR, 0, r, e);
		chk(r, 0);
		apb(0, CTRL_ONE_ADDR, 0, r, e);
		chk(r, 0);
		chk(ANALOG_PIN_O, 16'hFFFF);
		// Channel F and unimplemented bits 1 and 3 written with power off; those bits must read zero
		apb(1, CTRL_ZERO_ADDR, 32'hFA, r, e);
		apb(0, CTRL_ZERO_ADDR, 0, r, e);
		chk(r, 32'hF0);
		chk(CHANNEL_O, 4'hF);
		apb(1, CTRL_ONE_ADDR, 32'hFF, r, e);
		apb(0, CTRL_ONE_ADDR, 0, r, e);
		chk(r, 32'hEF);
		chk(EXT_REF_O, 1);
		wt(150);
		chk(DONE_O, 0);
		for (int n = 0; n < 8; n++) begin
			apb(1, CTRL_ONE_ADDR, n * 2, r, e);
			// Pin map follows the config register one cycle later
			wt(1);
			chk(ANALOG_PIN_O, {2{n == 7 ? 8'h00 : 8'hFF >> n}});
		end
		chk(EXT_REF_O, 0);
		apb(0, 10'h060, 0, r, e);
		chk(r, 0);
		chk(e, 1);
		$display("registers done");
		for (int s = 0; s < 4; s++) begin
			seed = lfsr(seed);
			vin <= (s == 0) ? 10'h3FF : (s == 1) ? 10'h000 : seed[9:0];
			ch = seed[13:10];
			j = seed[14];
			p = (s == 0) ? 8 : (s == 1) ? 32 : (s == 2) ? 64 : 10;
			apb(1, CTRL_ONE_ADDR, {s[1:0], j, 5'h0}, r, e);
			apb(1, CTRL_ZERO_ADDR, {ch, 4'h1}, r, e);
			chk(CHANNEL_O, ch);
			// Long enough for a slow-clock recovery to end before go
			wt(200);
			apb(1, STATUS_ADDR, 0, r, e);
			apb(1, CTRL_ZERO_ADDR, {ch, 4'h5}, r, e);
			t0 = cyc;
			SLEEP_I <= (s == 3);
			apb(0, CTRL_ZERO_ADDR, 0, r, e);
			chk(r[2], 1);
			while (DONE_O !== 1'b1 && cyc - t0 < 2000) wt(1);
			chk(cyc - t0 >= 11 * p && cyc - t0 <= 13 * p + 8, 1);
			chk(DONE_O, 1);
			SLEEP_I <= 1'b0;
			apb(0, CTRL_ZERO_ADDR, 0, r, e);
			chk(r, {ch, 4'h1});
			apb(0, RESULT_ADDR, 0, r, e);
			chk(r, res(vin, j));
		end
		$display("conversions done");
		for (int m = 0; m < 2; m++) begin
			apb(1, CTRL_ONE_ADDR, 32'h20, r, e);
			apb(1, RESULT_ADDR, 32'h0155, r, e);
			apb(1, STATUS_ADDR, 0, r, e);
			wt(100);
			apb(1, CTRL_ZERO_ADDR, 32'h05, r, e);
			wt(20);
			if (m == 0) apb(1, CTRL_ZERO_ADDR, 32'h01, r, e);
			else SLEEP_I <= 1'b1;
			wt(200);
			chk(DONE_O, 0);
			if (m == 0) chk(SAMPLE_CONNECT_O, 1);
			SLEEP_I <= 1'b0;
			apb(0, RESULT_ADDR, 0, r, e);
			chk(r, 32'h0155);
		end
		apb(1, CTRL_ZERO_ADDR, 0, r, e);
		wt(2);
		chk({POWER_ON_O, SAMPLE_CONNECT_O}, 0);
		$display("abort done");
		apb(1, CTRL_ZERO_ADDR, 32'h01, r, e);
		apb(1, CTRL_ZERO_ADDR, 32'h05, r, e);
		wt(200);
		RST_N_I <= 1'b0;
		wt(3);
		RST_N_I <= 1'b1;
		chk({DONE_O, POWER_ON_O}, 0);
		apb(0, CTRL_ZERO_ADDR, 0, r, e);
		chk(r, 0);
		$display("reset done");
		end_sim;
	end
endmodule // tb_sac_sequencer
